// file: verilog/rsc_pkg.sv
// How it works
// - writing the stop-select bit enters stop mode right after that write completes.
// - stop halts core and peripherals; watchdog frozen; external oscillator untouched.
// - only a reset ends stop; the core then restarts from address zero.
// - an enabled missing-clock detector timeout resets the device out of stop.
// - regulator-halt config shuts regulator in stop; then only pin or power-up reset.
// - power-up holds reset and drives pin low until supply good, then delay.
// - power-on or supply reset sets the power-on flag; other resets clear it.
// - supply monitor off after power-up; other resets keep its enable state.
// - supply below threshold drives pin low and holds reset until supply recovers.
// - writing one to the power-on flag position enables the supply monitor.
// - supply-monitor reset release skips the power-on delay.
// - power-fail reset keeps memory; power-on flag marks memory as undefined.
// - external low on the reset pin resets; pin flag set on entry to reset.
// - missing-clock one-shot timeout generates a reset.
// - missing-clock flag reads cause; writing it enables or disables detector.
// - enabled comparator reset fires while non-inverting input is below inverting.
// - comparator flag reads one after comparator or watchdog reset, zero otherwise.
// - only power-on and supply resets drive the reset pin low.
// - after any reset the watchdog runs enabled from system clock over twelve.
// - watchdog expiry resets and sets the watchdog flag in status bit three.
package rsc_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_POWER_CTRL   = 8'h00;
  localparam logic [7:0] OFS_REG_CTRL     = 8'h04;
  localparam logic [7:0] OFS_RESET_SOURCE = 8'h08;
  localparam logic [7:0] OFS_WDT_CTRL     = 8'h0C;
  localparam logic [7:0] OFS_WDT_KICK     = 8'h10;
  localparam logic [7:0] OFS_STATUS       = 8'h14;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_STOP_SEL   = 1;
  localparam int BIT_REG_HALT   = 0;
  localparam int BIT_PIN_FLAG   = 0;
  localparam int BIT_POR_FLAG   = 1;
  localparam int BIT_MCD_FLAG   = 2;
  localparam int BIT_CMP_FLAG   = 5;
  localparam int BIT_WDT_EN     = 0;
  localparam int LSB_WDT_LIMIT  = 8;
  localparam int BIT_ST_VMON    = 0;
  localparam int BIT_ST_MCD     = 1;
  localparam int BIT_ST_CMP     = 2;
  localparam int BIT_ST_WDT     = 3;
  localparam int BIT_ST_STOP    = 4;
  localparam int BIT_ST_REGOFF  = 5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic       RST_WDT_EN    = 1'b1;
  localparam logic [7:0] RST_WDT_LIMIT = 8'hFF;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 40;
  localparam int POR_DELAY_NS    = 300000;
  localparam int POR_DELAY_CYC   = POR_DELAY_NS / CLK_PERIOD_NS;
  localparam logic [3:0] WDT_PRESCALE = 4'hC;

  // ****************************************
  // sequencer states and causes
  // ****************************************
  typedef enum logic [3:0] {
    ST_POR  = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_RUN  = 4'b0100,
    ST_STOP = 4'b1000
  } rsc_state_e;

  typedef enum logic [4:0] {
    CS_VMON = 5'b00001,
    CS_PIN  = 5'b00010,
    CS_MCD  = 5'b00100,
    CS_CMP  = 5'b01000,
    CS_WDT  = 5'b10000
  } rsc_cause_e;
endpackage : rsc_pkg

// file: verilog/rsc_wdt.sv
`timescale 1ns/100ps
module rsc_wdt (
  input  wire logic       clk_sys,
  input  wire logic       clk_en,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       kick,
  input  wire logic [7:0] limit,
  output logic            expire
);
  logic [3:0] pre_r;
  logic [7:0] cnt_r;
  logic       tick;

  assign tick = (pre_r == rsc_pkg::WDT_PRESCALE - 4'h1);

  // ****************************************
  // divide by twelve prescaler
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst || kick) begin
      pre_r <= 4'h0;
    end else if (clk_en && run) begin
      pre_r <= tick ? 4'h0 : pre_r + 4'h1;
    end
  end

  // ****************************************
  // timeout counter
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst || kick) begin
      cnt_r  <= 8'h00;
      expire <= 1'b0;
    end else if (clk_en) begin
      expire <= 1'b0;
      if (run && tick) begin
        if (cnt_r == limit) begin
          expire <= 1'b1;
          cnt_r  <= 8'h00;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end
endmodule : rsc_wdt

// file: verilog/rsc_top.sv
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module rsc_top #(
  parameter int POR_DELAY = rsc_pkg::POR_DELAY_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  input  wire logic        supply_above_thresh,
  input  wire logic        comparator_below,
  input  wire logic        missing_clock_timeout,
  output logic             sys_reset_out,
  output logic             stop_mode,
  output logic             regulator_off
);
  // ****************************************
  // declarations
  // ****************************************
  rsc_pkg::rsc_state_e state_r;
  rsc_pkg::rsc_state_e state_nxt;
  rsc_pkg::rsc_cause_e cause_r;
  rsc_pkg::rsc_cause_e cause_nxt;

  logic [3:0]  sync1_r;
  logic [3:0]  sync2_r;
  logic        supply_ok;
  logic        cmp_low;
  logic        mcd_out;
  logic        pin_low;
  logic [1:0]  oe_dly_r;

  logic [31:0] por_cnt_r;
  logic        vmon_en_r;
  logic        mcd_en_r;
  logic        cmp_en_r;
  logic        stop_sel_r;
  logic        regulator_halt_cfg_r;
  logic        wdt_en_r;
  logic [7:0]  wdt_limit_r;
  logic        pin_flag_r;
  logic        power_on_reset_flag_r;
  logic        missing_clock_flag_r;
  logic        comparator_reset_flag_r;
  logic        watchdog_reset_flag_r;

  logic        dph_valid_r;
  logic        dph_write_r;
  logic [7:0]  dph_addr_r;
  logic        addr_phase;
  logic        wr_en;
  logic        wdt_kick;
  logic        wdt_expire;
  logic        any_rst;

  logic        trip_vmon;
  logic        trip_pin;
  logic        trip_mcd;
  logic        trip_cmp;
  logic        trip_any;
  logic        cause_active;

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      rsc_pkg::OFS_POWER_CTRL: begin
        d[rsc_pkg::BIT_STOP_SEL] = stop_sel_r;
      end
      rsc_pkg::OFS_REG_CTRL: begin
        d[rsc_pkg::BIT_REG_HALT] = regulator_halt_cfg_r;
      end
      rsc_pkg::OFS_RESET_SOURCE: begin
        d[rsc_pkg::BIT_PIN_FLAG] = pin_flag_r;
        d[rsc_pkg::BIT_POR_FLAG] = power_on_reset_flag_r;
        d[rsc_pkg::BIT_MCD_FLAG] = missing_clock_flag_r;
        d[rsc_pkg::BIT_CMP_FLAG] = comparator_reset_flag_r | watchdog_reset_flag_r;
      end
      rsc_pkg::OFS_WDT_CTRL: begin
        d[rsc_pkg::BIT_WDT_EN] = wdt_en_r;
        d[rsc_pkg::LSB_WDT_LIMIT +: 8] = wdt_limit_r;
      end
      rsc_pkg::OFS_STATUS: begin
        d[rsc_pkg::BIT_ST_VMON]   = vmon_en_r;
        d[rsc_pkg::BIT_ST_MCD]    = mcd_en_r;
        d[rsc_pkg::BIT_ST_CMP]    = cmp_en_r;
        d[rsc_pkg::BIT_ST_WDT]    = watchdog_reset_flag_r;
        d[rsc_pkg::BIT_ST_STOP]   = stop_mode;
        d[rsc_pkg::BIT_ST_REGOFF] = regulator_off;
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    return d;
  endfunction : read_mux

  // ****************************************
  // input synchronisers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      sync1_r <= {missing_clock_timeout, comparator_below, supply_above_thresh, rst_pin_in};
      sync2_r <= sync1_r;
      oe_dly_r <= {oe_dly_r[0], rst_pin_oe};
    end
  end

  assign pin_low   = ~sync2_r[0];
  assign supply_ok = sync2_r[1];
  assign cmp_low   = sync2_r[2];
  assign mcd_out   = sync2_r[3];

  // ****************************************
  // reset source detection
  // ****************************************
  // sources lost with regulator off
  assign trip_vmon = vmon_en_r & ~supply_ok & ~regulator_off;
  // external pin, ignored while driven and two cycles after
  assign trip_pin  = pin_low & ~rst_pin_oe & ~|oe_dly_r;
  assign trip_mcd  = mcd_en_r & mcd_out & ~regulator_off;
  assign trip_cmp  = cmp_en_r & cmp_low & ~regulator_off;
  assign trip_any  = trip_vmon | trip_pin | trip_mcd | trip_cmp | wdt_expire;

  always_comb begin
    cause_nxt = cause_r;
    // one cause per event, fixed priority
    if (trip_vmon) begin
      cause_nxt = rsc_pkg::CS_VMON;
    end else if (trip_pin) begin
      cause_nxt = rsc_pkg::CS_PIN;
    end else if (trip_mcd) begin
      cause_nxt = rsc_pkg::CS_MCD;
    end else if (trip_cmp) begin
      cause_nxt = rsc_pkg::CS_CMP;
    end else if (wdt_expire) begin
      cause_nxt = rsc_pkg::CS_WDT;
    end
  end

  always_comb begin
    case (cause_r)
      rsc_pkg::CS_VMON: cause_active = ~supply_ok;
      rsc_pkg::CS_PIN:  cause_active = pin_low;
      rsc_pkg::CS_MCD:  cause_active = mcd_out;
      rsc_pkg::CS_CMP:  cause_active = cmp_low;
      default:          cause_active = 1'b0;
    endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rsc_pkg::ST_POR: begin
        // wait for supply, then power-on delay
        if (supply_ok && por_cnt_r >= 32'(POR_DELAY)) begin
          state_nxt = rsc_pkg::ST_RUN;
        end
      end
      rsc_pkg::ST_HOLD: begin
        if (!cause_active) begin
          state_nxt = rsc_pkg::ST_RUN;
        end
      end
      rsc_pkg::ST_RUN: begin
        if (trip_any) begin
          state_nxt = rsc_pkg::ST_HOLD;
        end else if (wr_en && reg_hit(dph_addr_r, rsc_pkg::OFS_POWER_CTRL)
                     && hwdata[rsc_pkg::BIT_STOP_SEL]) begin
          state_nxt = rsc_pkg::ST_STOP;
        end
      end
      rsc_pkg::ST_STOP: begin
        if (trip_any) begin
          state_nxt = rsc_pkg::ST_HOLD;
        end
      end
      default: begin
        state_nxt = rsc_pkg::ST_POR;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r   <= rsc_pkg::ST_POR;
      por_cnt_r <= 32'h0000_0000;
      cause_r   <= rsc_pkg::CS_VMON;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (state_r == rsc_pkg::ST_POR && supply_ok) begin
        por_cnt_r <= por_cnt_r + 32'h0000_0001;
      end else begin
        por_cnt_r <= 32'h0000_0000;
      end
      if (state_nxt == rsc_pkg::ST_HOLD && state_r != rsc_pkg::ST_HOLD) begin
        cause_r <= cause_nxt;
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sys_reset_out <= 1'b1;
      rst_pin_oe    <= 1'b1;
      rst_pin_out   <= 1'b0;
      stop_mode     <= 1'b0;
      regulator_off <= 1'b0;
    end else if (clk_en) begin
      sys_reset_out <= (state_nxt == rsc_pkg::ST_POR) || (state_nxt == rsc_pkg::ST_HOLD);
      // only power-on and supply drive the pin
      rst_pin_oe    <= (state_nxt == rsc_pkg::ST_POR) ||
                       (state_nxt == rsc_pkg::ST_HOLD && cause_nxt == rsc_pkg::CS_VMON);
      rst_pin_out   <= 1'b0;
      // halt core and peripherals in stop
      stop_mode     <= (state_nxt == rsc_pkg::ST_STOP);
      regulator_off <= (state_nxt == rsc_pkg::ST_STOP) && regulator_halt_cfg_r;
    end
  end

  // ****************************************
  // reset cause flags
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_flag_r              <= 1'b0;
      power_on_reset_flag_r   <= 1'b1;
      missing_clock_flag_r    <= 1'b0;
      comparator_reset_flag_r <= 1'b0;
      watchdog_reset_flag_r   <= 1'b0;
    end else if (clk_en && state_r == rsc_pkg::ST_RUN && state_nxt == rsc_pkg::ST_RUN) begin
      // flags stay as captured while running
    end else if (clk_en && state_nxt == rsc_pkg::ST_HOLD && state_r != rsc_pkg::ST_HOLD) begin
      // power-on flag for supply reset, cleared by others
      // flag tells software memory may be undefined
      power_on_reset_flag_r   <= (cause_nxt == rsc_pkg::CS_VMON);
      pin_flag_r              <= (cause_nxt == rsc_pkg::CS_PIN);
      missing_clock_flag_r    <= (cause_nxt == rsc_pkg::CS_MCD);
      comparator_reset_flag_r <= (cause_nxt == rsc_pkg::CS_CMP);
      watchdog_reset_flag_r   <= (cause_nxt == rsc_pkg::CS_WDT);
    end
  end

  // ****************************************
  // supply monitor enable
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vmon_en_r <= 1'b0;
    end else if (clk_en && wr_en && reg_hit(dph_addr_r, rsc_pkg::OFS_RESET_SOURCE)
                 && hwdata[rsc_pkg::BIT_POR_FLAG]) begin
      vmon_en_r <= 1'b1;
    end
  end

  // ****************************************
  // control registers cleared by any reset
  // ****************************************
  assign any_rst = sys_rst | sys_reset_out;

  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      mcd_en_r             <= 1'b0;
      cmp_en_r             <= 1'b0;
      stop_sel_r           <= 1'b0;
      regulator_halt_cfg_r <= 1'b0;
    end else if (clk_en && wr_en) begin
      if (reg_hit(dph_addr_r, rsc_pkg::OFS_RESET_SOURCE)) begin
        mcd_en_r <= hwdata[rsc_pkg::BIT_MCD_FLAG];
        // software enables only a settled comparator
        cmp_en_r <= hwdata[rsc_pkg::BIT_CMP_FLAG];
      end
      if (reg_hit(dph_addr_r, rsc_pkg::OFS_POWER_CTRL)) begin
        stop_sel_r <= hwdata[rsc_pkg::BIT_STOP_SEL];
      end
      if (reg_hit(dph_addr_r, rsc_pkg::OFS_REG_CTRL)) begin
        regulator_halt_cfg_r <= hwdata[rsc_pkg::BIT_REG_HALT];
      end
    end
  end

  // ****************************************
  // watchdog
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      wdt_en_r    <= rsc_pkg::RST_WDT_EN;
      wdt_limit_r <= rsc_pkg::RST_WDT_LIMIT;
    end else if (clk_en && wr_en && reg_hit(dph_addr_r, rsc_pkg::OFS_WDT_CTRL)) begin
      wdt_en_r    <= hwdata[rsc_pkg::BIT_WDT_EN];
      wdt_limit_r <= hwdata[rsc_pkg::LSB_WDT_LIMIT +: 8];
    end
  end

  assign wdt_kick = wr_en && reg_hit(dph_addr_r, rsc_pkg::OFS_WDT_KICK);

  // system clock over twelve, frozen in stop
  rsc_wdt u_wdt (
    .clk_sys (clk_sys),
    .clk_en  (clk_en),
    .rst     (any_rst),
    .run     (wdt_en_r && state_r == rsc_pkg::ST_RUN),
    .kick    (wdt_kick),
    .limit   (wdt_limit_r),
    .expire  (wdt_expire)
  );

  // ****************************************
  // bus slave
  // ****************************************
  assign addr_phase = hsel & htrans[1] & hready;
  assign wr_en      = dph_valid_r & dph_write_r & ~sys_reset_out;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r  <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else if (clk_en) begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      dph_valid_r <= addr_phase;
      dph_write_r <= hwrite;
      if (addr_phase) begin
        dph_addr_r <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
        hrdata     <= (!hwrite && haddr[31:8] == 24'h000000) ? read_mux(haddr[7:0]) : 32'h0000_0000;
      end
    end
  end

  logic unused_size;
  assign unused_size = ^hsize;
endmodule : rsc_top

// file: tb/rsc_env.sv
`timescale 1ns/100ps
module rsc_env (
  input  wire logic rst_pin_out,
  input  wire logic rst_pin_oe,
  input  wire logic ext_low,
  input  wire logic supply_ok,
  input  wire logic cmp_low,
  input  wire logic mcd_to,
  output logic      rst_pin_in,
  output logic      supply_above_thresh,
  output logic      comparator_below,
  output logic      missing_clock_timeout
);
  // ****************************************
  // board side of the reset pin and sensors
  // ****************************************
  // outside pin drive
  // released pin returns high through the board pull-up
  assign rst_pin_in = !(ext_low || (rst_pin_oe && !rst_pin_out));
  assign supply_above_thresh = supply_ok;
  assign comparator_below = cmp_low;
  assign missing_clock_timeout = mcd_to;
endmodule : rsc_env

// file: tb/rsc_asserts.sv
`timescale 1ns/100ps
module rsc_asserts #(
  parameter int POR_DELAY = 8
) (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rst_pin_in,
  input wire logic        rst_pin_oe,
  input wire logic        sys_reset_out,
  input wire logic        stop_mode,
  input wire logic        regulator_off
);
  // ****************************************
  // cycle count since power-up and properties
  // ****************************************
  logic [15:0] up_cnt_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) up_cnt_r <= 16'h0000;
    else if (up_cnt_r != 16'hFFFF) up_cnt_r <= up_cnt_r + 16'h0001;
  end
  sequence s_stop_addr;
    hsel && htrans[1] && hwrite && hready && haddr[7:0] == 8'h00 && !sys_reset_out;
  endsequence
  sequence s_stop_data;
    hwdata[1] && !sys_reset_out;
  endsequence
  property p_stop_entry;
    s_stop_addr ##1 s_stop_data |-> ##[1:3] stop_mode;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop write did not stop");
  property p_stop_exit;
    $fell(stop_mode) |-> sys_reset_out;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stop left without reset");
  property p_reg_stop;
    regulator_off && !sys_reset_out |-> stop_mode;
  endproperty
  a_reg_stop: assert property (p_reg_stop) else $error("regulator off outside stop");
  property p_reg_pin_only;
    (regulator_off && rst_pin_in) [*4] |-> !sys_reset_out;
  endproperty
  a_reg_pin_only: assert property (p_reg_pin_only) else $error("reset while regulator off");
  property p_pin_trip;
    (!rst_pin_in && !rst_pin_oe) [*4] |-> ##1 sys_reset_out;
  endproperty
  a_pin_trip: assert property (p_pin_trip) else $error("low pin gave no reset");
  property p_oe_cause;
    rst_pin_oe |-> sys_reset_out || $past(sys_reset_out);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin driven outside reset");
  property p_por_hold;
    up_cnt_r <= POR_DELAY |-> sys_reset_out && rst_pin_oe;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-up released early");
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus wait or error seen");
endmodule : rsc_asserts

bind rsc_top rsc_asserts #(.POR_DELAY(POR_DELAY)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .rst_pin_in(rst_pin_in),
  .rst_pin_oe(rst_pin_oe), .sys_reset_out(sys_reset_out), .stop_mode(stop_mode),
  .regulator_off(regulator_off));

// file: tb/tb_rsc_top.sv
`timescale 1ns/100ps
module tb_rsc_top;
  // ****************************************
  // bench wiring, tasks and scenarios
  // ****************************************
  localparam int PD = 8;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        ext_low = 1'b0, supply_ok = 1'b0, cmp_low = 1'b0, mcd_to = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, rst_pin_in, rst_pin_out, rst_pin_oe, sup, cmpb, mct;
  logic        sys_reset_out, stop_mode, regulator_off;
  wire logic   hready;
  int          n_fail = 0, num_checks = 0, cyc = 0;
  logic [31:0] exp_q[$];

  assign hready = hreadyout;
  always #20 clk_sys = ~clk_sys;

  rsc_env env_u (.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .ext_low(ext_low), .supply_ok(supply_ok),
    .cmp_low(cmp_low), .mcd_to(mcd_to), .rst_pin_in(rst_pin_in), .supply_above_thresh(sup),
    .comparator_below(cmpb), .missing_clock_timeout(mct));
  rsc_top #(.POR_DELAY(PD)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .supply_above_thresh(sup), .comparator_below(cmpb), .missing_clock_timeout(mct),
    .sys_reset_out(sys_reset_out), .stop_mode(stop_mode), .regulator_off(regulator_off));

  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    r = hrdata;
  endtask : bus

  task automatic wt(input logic v, output int n);
    n = 0;
    while (sys_reset_out !== v) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wt

  task automatic after_rst(input logic [31:0] mask);
    int n;
    logic [31:0] r;
    wt(1'b0, n);
    bus(1'b0, 8'h08, 32'h0, r);
    chk("reset_source_reg", r & mask, exp_q.pop_front() & mask);
    bus(1'b0, 8'h0C, 32'h0, r);
    chk("wdt_ctrl", r, 32'h0000FF01);
    bus(1'b1, 8'h0C, 32'h0, r);
  endtask : after_rst

  initial begin
    int n;
    int lim;
    logic [31:0] r;
    void'($urandom(25));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat ($urandom_range(15, 5)) begin
      @(posedge clk_sys);
      chk("por_hold", 32'({sys_reset_out, rst_pin_oe}), 32'h3);
    end
    supply_ok <= 1'b1;
    wt(1'b0, n);
    chk("por_delay", 32'(n >= PD + 1 && n <= PD + 6), 32'h1);
    exp_q.push_back(32'h2);
    after_rst(32'h2);
    bus(1'b0, 8'h14, 32'h0, r);
    chk("status", r & 32'h37, 32'h0);
    bus(1'b1, 8'h20, $urandom, r);
    bus(1'b0, 8'h20, 32'h0, r);
    chk("unmapped", r, 32'h0);
    bus(1'b1, 8'h08, 32'h2, r);
    bus(1'b0, 8'h14, 32'h0, r);
    chk("vmon_en", r & 32'h1, 32'h1);
    // clock enable low freezes the supply monitor path
    clk_en <= 1'b0;
    supply_ok <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("frozen", 32'(sys_reset_out), 32'h0);
    supply_ok <= 1'b1;
    repeat (2) @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("thawed", 32'(sys_reset_out), 32'h0);
    supply_ok <= 1'b0;
    wt(1'b1, n);
    repeat (3) @(posedge clk_sys);
    chk("vmon_pin", 32'({sys_reset_out, rst_pin_oe, rst_pin_out}), 32'h6);
    supply_ok <= 1'b1;
    wt(1'b0, n);
    chk("vmon_fast", 32'(n <= 6), 32'h1);
    exp_q.push_back(32'h2);
    after_rst(32'h2);
    ext_low <= 1'b1;
    wt(1'b1, n);
    repeat ($urandom_range(6, 2)) @(posedge clk_sys);
    chk("pin_oe", 32'({sys_reset_out, rst_pin_oe}), 32'h2);
    ext_low <= 1'b0;
    exp_q.push_back(32'h1);
    after_rst(32'h27);
    bus(1'b0, 8'h14, 32'h0, r);
    chk("vmon_kept", r & 32'h1, 32'h1);
    bus(1'b1, 8'h08, 32'h4, r);
    bus(1'b1, 8'h08, 32'h0, r);
    mcd_to <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("mcd_off", 32'(sys_reset_out), 32'h0);
    mcd_to <= 1'b0;
    repeat (3) @(posedge clk_sys);
    // comparator input stays settled low until after its source is enabled
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h08, i ? 32'h20 : 32'h4, r);
      bus(1'b0, 8'h14, 32'h0, r);
      chk("src_en", r & 32'h6, i ? 32'h4 : 32'h2);
      if (i) cmp_low <= 1'b1;
      else mcd_to <= 1'b1;
      wt(1'b1, n);
      repeat (2) @(posedge clk_sys);
      chk("no_pin", 32'(rst_pin_oe), 32'h0);
      cmp_low <= 1'b0;
      mcd_to <= 1'b0;
      exp_q.push_back(i ? 32'h20 : 32'h4);
      after_rst(32'h27);
    end
    lim = $urandom_range(3, 1);
    bus(1'b1, 8'h0C, 32'((lim << 8) | 1), r);
    bus(1'b1, 8'h10, 32'h0, r);
    wt(1'b1, n);
    chk("wdt_time", 32'(n >= lim * 12 && n <= lim * 12 + 16), 32'h1);
    exp_q.push_back(32'h20);
    after_rst(32'h27);
    bus(1'b0, 8'h14, 32'h0, r);
    chk("wdt_flag", r & 32'h8, 32'h8);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, 8'h04, 32'(j), r);
      bus(1'b1, 8'h08, 32'h4, r);
      bus(1'b1, 8'h00, 32'h2, r);
      repeat (3) @(posedge clk_sys);
      chk("stop", 32'({stop_mode, regulator_off}), j ? 32'h3 : 32'h2);
      mcd_to <= 1'b1;
      repeat (12) @(posedge clk_sys);
      chk("stop_held", 32'({stop_mode, sys_reset_out}), j ? 32'h2 : 32'h1);
      if (j) ext_low <= 1'b1;
      wt(1'b1, n);
      repeat (4) @(posedge clk_sys);
      mcd_to <= 1'b0;
      ext_low <= 1'b0;
      exp_q.push_back(j ? 32'h1 : 32'h4);
      after_rst(32'h27);
      chk("stop_exit", 32'({stop_mode, regulator_off}), 32'h0);
    end
    wrap_up();
  end
endmodule : tb_rsc_top
